// ==== shared/twsio_pkg.sv ====
// Package for the three-wire serial I/O port: register map, field
// positions, reset values, divider counts and the shared types.
// Assumes a single 100 MHz clock and an asynchronous active-high reset.
package twsio_pkg;

	// Register byte addresses on the plain register port
	localparam logic [15:0] MODE_ADDR  = 16'hff78;
	localparam logic [15:0] SHIFT_ADDR = 16'hff7a;
	localparam logic [15:0] LATCH_ADDR = 16'hff22;
	localparam logic [15:0] DIR_ADDR   = 16'hff42;

	// Mode control fields
	localparam int EN_BIT    = 7;
	localparam int DIV_HI    = 5;
	localparam int DIV_LO    = 4;
	localparam int ORDER_BIT = 2;
	localparam int SRC_BIT   = 1;
	localparam logic [7:0] MODE_WMASK = 8'hb6;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Port pin indexes and reset values
	localparam int PIN_SCK = 0;
	localparam int PIN_SO  = 1;
	localparam int PIN_SI  = 2;
	localparam logic [2:0] LATCH_RESET = 3'h0;
	localparam logic [2:0] DIR_RESET   = 3'h7;

	// Half period of the serial clock, minus one, per divide code
	localparam logic [3:0] HALF_DIV4  = 4'h1;
	localparam logic [3:0] HALF_DIV8  = 4'h3;
	localparam logic [3:0] HALF_DIV16 = 4'h7;
	localparam logic [3:0] HALF_DIV32 = 4'hf;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	typedef enum logic {TWSIO_IDLE, TWSIO_SHIFT} twsio_phase_t;

	// One bit per pin of the port
	typedef struct packed {
		logic si;
		logic so;
		logic sck;
	} twsio_pins_t;

	// Whole state of the port
	typedef struct packed {
		logic [7:0]   mode;
		logic [7:0]   sr;
		logic [2:0]   latch;
		logic [2:0]   dir;
		twsio_phase_t phase;
		logic         sck;
		logic         so;
		logic [2:0]   bits;
		logic         sck_prev;
		logic         cap;
		logic         irq;
		logic [7:0]   rdata;
	} twsio_state_t;

endpackage

// ==== hw/twsio_sync.sv ====
// Two-flop synchroniser for the three port pins.
// Assumes the pins are asynchronous to i_ref_clk.
`timescale 1ns/10ps
module twsio_sync (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst,
	input  wire twsio_pkg::twsio_pins_t i_pins,
	output twsio_pkg::twsio_pins_t     o_pins
);
	logic [2:0] meta_q;
	logic [2:0] sync_q;

	// Reset high so an idle clock pin does not look like an edge
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_bit
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_q[gi] <= 1'b1;
					sync_q[gi] <= 1'b1;
				end else begin
					meta_q[gi] <= i_pins[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	assign o_pins = sync_q;
endmodule

// ==== hw/twsio_div.sv ====
// Divider giving one-cycle pulses at each half period of the
// internal serial clock. Held cleared while no transfer runs.
`timescale 1ns/10ps
module twsio_div (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_clear,
	input  wire logic [1:0] i_sel,
	output logic            o_tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] limit;

	// Divide by 4, 8, 16 or 32 of the main clock
	always_comb begin
		case (i_sel)
			2'h0:    limit = twsio_pkg::HALF_DIV4;
			2'h1:    limit = twsio_pkg::HALF_DIV8;
			2'h2:    limit = twsio_pkg::HALF_DIV16;
			default: limit = twsio_pkg::HALF_DIV32;
		endcase
		o_tick = !i_clear && (cnt_q == limit);
		if (i_clear || o_tick) begin
			cnt_d = 4'h0;
		end else begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	// Counter register
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// ==== hw/twsio_port.sv ====
// Three-wire serial I/O port: mode register, shift register, serial
// clock generation or reception, and the three shared port pins.
// Assumes a register master on i_ref_clk that never waits.
`timescale 1ns/10ps
module twsio_port (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst,
	input  wire logic [15:0]           i_addr,
	input  wire logic [7:0]            i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic [7:0]                 o_rdata,
	input  wire twsio_pkg::twsio_pins_t i_pin,
	output twsio_pkg::twsio_pins_t     o_pin,
	output twsio_pkg::twsio_pins_t     o_pin_oe,
	output logic                       o_transfer_done_irq
);
	twsio_pkg::twsio_state_t q;
	twsio_pkg::twsio_state_t d;
	twsio_pkg::twsio_pins_t  pin_s;
	logic                    tick;
	logic                    en;
	logic                    internal;
	logic                    lsb_first;
	logic                    running;
	logic                    fall;
	logic                    rise;
	logic                    start_ok;

	// Pins are asynchronous, so each passes two flops first
	twsio_sync u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_pins    (i_pin),
		.o_pins    (pin_s)
	);

	// Internal serial clock comes from the main clock only
	twsio_div u_div (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_clear   (!running || !internal),
		.i_sel     (q.mode[twsio_pkg::DIV_HI:twsio_pkg::DIV_LO]),
		.o_tick    (tick)
	);

	// Mode decode
	assign en        = q.mode[twsio_pkg::EN_BIT];
	assign internal  = q.mode[twsio_pkg::SRC_BIT];
	assign lsb_first = q.mode[twsio_pkg::ORDER_BIT];
	assign running   = (q.phase == twsio_pkg::TWSIO_SHIFT);

	// Serial clock edges from the divider or from the pin
	always_comb begin
		if (internal) begin
			fall = running && tick && q.sck;
			rise = running && tick && !q.sck;
		end else begin
			fall = running && q.sck_prev && !pin_s.sck;
			rise = running && !q.sck_prev && pin_s.sck;
		end
	end

	// Start only when enabled and the clock rests high after a byte
	assign start_ok = en && !running
		&& (internal || pin_s.sck);

	// Next state: shifting first, then register writes
	always_comb begin
		d = q;
		d.irq = 1'b0;
		d.sck_prev = pin_s.sck;
		// Capture waits a cycle: the synchronised input lags the pin by
		// two clocks, so a far end that moves on the fall is seen in time
		d.cap = rise;
		if (internal && running && tick) begin
			d.sck = !q.sck;
		end
		// Outgoing bit moves to the output latch on the fall
		if (fall) begin
			d.so = lsb_first ? q.sr[0] : q.sr[7];
		end
		// Incoming bit lands in the input end one cycle after the rise
		if (q.cap && running) begin
			if (lsb_first) begin
				d.sr = {pin_s.si, q.sr[7:1]};
			end else begin
				d.sr = {q.sr[6:0], pin_s.si};
			end
			d.bits = q.bits + 3'h1;
			if (q.bits == twsio_pkg::LAST_BIT) begin
				d.phase = twsio_pkg::TWSIO_IDLE;
				d.irq = 1'b1;
			end
		end
		if (i_wr) begin
			case (i_addr)
				twsio_pkg::MODE_ADDR: begin
					// Reserved bits always read back zero
					d.mode = i_wdata & twsio_pkg::MODE_WMASK;
				end
				twsio_pkg::SHIFT_ADDR: begin
					// External master may already be clocking this byte
					if (internal || !running) begin
						d.sr = i_wdata;
					end
					if (start_ok) begin
						d.phase = twsio_pkg::TWSIO_SHIFT;
						d.bits = 3'h0;
						d.sck = 1'b1;
					end
				end
				twsio_pkg::LATCH_ADDR: begin
					d.latch = i_wdata[2:0];
				end
				twsio_pkg::DIR_ADDR: begin
					d.dir = i_wdata[2:0];
				end
				default: begin
				end
			endcase
		end
		// Disabling stops a byte dead; a stale write never resumes
		if (!en) begin
			d.phase = twsio_pkg::TWSIO_IDLE;
			d.sck = 1'b1;
		end
		// Read data for the cycle after the strobe
		d.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				twsio_pkg::MODE_ADDR:  d.rdata = q.mode;
				twsio_pkg::SHIFT_ADDR: d.rdata = q.sr;
				twsio_pkg::LATCH_ADDR: d.rdata = {5'h00, pin_s};
				twsio_pkg::DIR_ADDR:   d.rdata = {5'h00, q.dir};
				default:               d.rdata = 8'h00;
			endcase
		end
	end

	// State register; the shift register reset value is arbitrary
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q.mode     <= twsio_pkg::MODE_RESET;
			q.sr       <= 8'h00;
			q.latch    <= twsio_pkg::LATCH_RESET;
			q.dir      <= twsio_pkg::DIR_RESET;
			q.phase    <= twsio_pkg::TWSIO_IDLE;
			q.sck      <= 1'b1;
			q.so       <= 1'b0;
			q.bits     <= 3'h0;
			q.sck_prev <= 1'b1;
			q.cap      <= 1'b0;
			q.irq      <= 1'b0;
			q.rdata    <= 8'h00;
		end else begin
			q <= d;
		end
	end

	// Pin muxing: so, and sck when internal, serial when enabled; si and the rest from the latch.
	// Clock output is gated by its latch, so software must set it high.
	always_comb begin
		o_pin_oe.sck = !q.dir[twsio_pkg::PIN_SCK];
		o_pin_oe.so  = !q.dir[twsio_pkg::PIN_SO];
		o_pin_oe.si  = !q.dir[twsio_pkg::PIN_SI];
		o_pin.si     = q.latch[twsio_pkg::PIN_SI];
		if (en && internal) begin
			o_pin.sck = q.sck && q.latch[twsio_pkg::PIN_SCK];
		end else begin
			o_pin.sck = q.latch[twsio_pkg::PIN_SCK];
		end
		if (en) begin
			o_pin.so = q.so;
		end else begin
			o_pin.so = q.latch[twsio_pkg::PIN_SO];
		end
	end

	assign o_rdata             = q.rdata;
	assign o_transfer_done_irq = q.irq;

	// Helper: cycles since the last divider tick
	logic [4:0] gap_q;
	logic       gap_ok_q;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_q    <= 5'h00;
			gap_ok_q <= 1'b0;
		end else if (tick) begin
			gap_q    <= 5'h00;
			gap_ok_q <= 1'b1;
		end else begin
			gap_q    <= gap_q + 5'h01;
			gap_ok_q <= gap_ok_q && running && internal;
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	AST_MODE_READBACK: assert property (
		i_rd && i_addr == twsio_pkg::MODE_ADDR && !i_wr
		|=> o_rdata == $past(q.mode))
		else $error("Mode register read back wrong");

	AST_DISABLED_IDLE: assert property (
		!en && !i_wr
		|=> !running ##0 o_pin.so == q.latch[twsio_pkg::PIN_SO])
		else $error("Port shifts while disabled");

	AST_DIV_SPACING: assert property (
		tick && gap_ok_q && q.mode[5:4] == 2'h0 |-> gap_q == 5'h01)
		else $error("Divide by four half period wrong");

	AST_MSB_CAPTURE: assert property (
		q.cap && running && !lsb_first && !i_wr && en
		|=> q.sr[0] == $past(pin_s.si) && q.sr[7:1] == $past(q.sr[6:0]))
		else $error("MSB first capture wrong");

	AST_LSB_CAPTURE: assert property (
		q.cap && running && lsb_first && !i_wr && en
		|=> q.sr[7] == $past(pin_s.si))
		else $error("LSB first capture wrong");

	AST_SO_ON_FALL: assert property (
		running && en && q.so != d.so |-> fall)
		else $error("Output latch moved off a falling edge");

	AST_DONE_AFTER_EIGHT: assert property (
		o_transfer_done_irq |-> $past(q.bits) == 3'h7 && !running
		##1 !o_transfer_done_irq)
		else $error("Done pulse not after the eighth bit");

	AST_NO_START_DISABLED: assert property (
		i_wr && i_addr == twsio_pkg::SHIFT_ADDR && !en |=> !running)
		else $error("Transfer started while disabled");

	AST_EXT_NO_OVERWRITE: assert property (
		running && !internal && !q.cap && en |=> q.sr == $past(q.sr))
		else $error("External mode byte overwritten");

	AST_IDLE_CLOCK_HIGH: assert property (
		!running && en && internal |-> q.sck)
		else $error("Internal clock not idling high");
endmodule

// ==== sim/twsio_peer.sv ====
// Far-end peripheral model: shifts one byte out on si and in from so.
// Assumes the device samples si on rising sck; the clock idles high.
`timescale 1ns/10ps
module twsio_peer (
	input  wire logic       i_ref_clk,
	input  wire logic       i_sck,
	input  wire logic       i_so,
	input  wire logic       i_lsb,
	input  wire logic [7:0] i_tx,
	output logic            o_si,
	output logic            o_sck,
	output logic [7:0]      o_rx
);
	int n = 8;

	initial begin
		o_si = 1'b0;
		o_sck = 1'b1;
		o_rx = 8'h00;
	end

	// Arm for a new byte
	task automatic start();
		n = 0;
		o_rx = 8'h00;
	endtask

	// New bit after each fall gives the device a full half period
	always @(negedge i_sck) begin
		if (n < 8)
			o_si <= i_lsb ? i_tx[n] : i_tx[7-n];
	end

	// Capture on the rise; once done, si is released and wanders
	always @(posedge i_sck) begin
		if (n < 8) begin
			o_rx <= i_lsb ? {i_so, o_rx[7:1]} : {o_rx[6:0], i_so};
			n <= n + 1;
		end else
			o_si <= ~o_si;
	end

	// Clock master: eight periods, standing high between frames
	task automatic ext_byte(input int half);
		repeat (8) begin
			repeat (half) @(posedge i_ref_clk);
			o_sck <= 1'b0;
			repeat (half) @(posedge i_ref_clk);
			o_sck <= 1'b1;
		end
	endtask
endmodule

// ==== sim/twsio_port_tb_top.sv ====
// Testbench for the serial port: registers, internal and external
// clocked bytes, disabled writes and plain port pins.
// Assumes the peer model and a pull-up on the serial output line.
`timescale 1ns/10ps
module twsio_port_tb_top;
	logic                   i_ref_clk = 1'b0;
	logic                   i_rst = 1'b1;
	logic [15:0]            i_addr = 16'h0000;
	logic [7:0]             i_wdata = 8'h00;
	logic                   i_wr = 1'b0;
	logic                   i_rd = 1'b0;
	logic [7:0]             o_rdata;
	twsio_pkg::twsio_pins_t pin_w;
	twsio_pkg::twsio_pins_t o_pin;
	twsio_pkg::twsio_pins_t o_pin_oe;
	logic                   o_transfer_done_irq;
	logic                   peer_si, peer_sck, sck_p = 1'b1, lsb = 1'b0;
	logic [7:0]             tx = 8'h00, rx, rd_v;
	int                     num_errors = 0, n_tests = 0;
	int                     n_done = 0, falls = 0, lows = 0;

	always #5 i_ref_clk = ~i_ref_clk;

	// Each line resolved from the device's enables; the peer or a pull-up drives it otherwise
	assign pin_w = {o_pin_oe.si ? o_pin.si : peer_si,
		o_pin_oe.so ? o_pin.so : 1'b1,
		o_pin_oe.sck ? o_pin.sck : peer_sck};

	twsio_port u_twsio_port (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_pin(pin_w), .o_pin(o_pin),
		.o_pin_oe(o_pin_oe), .o_transfer_done_irq(o_transfer_done_irq));

	twsio_peer u_twsio_peer (.i_ref_clk(i_ref_clk), .i_sck(pin_w.sck),
		.i_so(pin_w.so), .i_lsb(lsb), .i_tx(tx), .o_si(peer_si),
		.o_sck(peer_sck), .o_rx(rx));

	// Count clock falls, low cycles and done pulses
	always @(posedge i_ref_clk) begin
		sck_p <= pin_w.sck;
		if (sck_p && !pin_w.sck)
			falls++;
		if (!pin_w.sck)
			lows++;
		if (o_transfer_done_irq === 1'b1)
			n_done++;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobe then one idle edge, so no signal is set twice at one edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	task automatic rd(input logic [15:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		// Data stand only in this cycle; take them mid-cycle
		@(negedge i_ref_clk);
		rd_v = o_rdata;
		@(posedge i_ref_clk);
	endtask

	task automatic wait_done(input int bound);
		int s;
		s = n_done;
		repeat (bound) if (n_done == s) @(posedge i_ref_clk);
		chk(8'(n_done - s), 8'h01);
	endtask

	task automatic t_reset();
		rd(twsio_pkg::MODE_ADDR);
		chk(rd_v, 8'h00);
		chk({5'h0, o_pin_oe}, 8'h00);
		rd(16'hff00);
		chk(rd_v, 8'h00);
		wr(twsio_pkg::MODE_ADDR, 8'hff);
		rd(twsio_pkg::MODE_ADDR);
		chk(rd_v, 8'hb6);
	endtask

	task automatic t_ports();
		wr(twsio_pkg::MODE_ADDR, 8'h00);
		wr(twsio_pkg::DIR_ADDR, 8'h00);
		wr(twsio_pkg::LATCH_ADDR, 8'h05);
		chk({5'h0, o_pin}, 8'h05);
		chk({5'h0, o_pin_oe}, 8'h07);
		wr(twsio_pkg::MODE_ADDR, 8'h82);
		wr(twsio_pkg::LATCH_ADDR, 8'h04);
		chk({7'h0, o_pin.si}, 8'h01);
	endtask

	task automatic t_internal(input logic [1:0] code);
		lsb = code[0];
		tx = 8'h3c ^ code;
		wr(twsio_pkg::LATCH_ADDR, 8'h03);
		wr(twsio_pkg::DIR_ADDR, 8'h04);
		wr(twsio_pkg::MODE_ADDR, 8'h82 | (code << 4) | (lsb << 2));
		u_twsio_peer.start();
		falls = 0;
		lows = 0;
		wr(twsio_pkg::SHIFT_ADDR, 8'ha5 + code);
		wait_done(600);
		chk(rx, 8'ha5 + code);
		rd(twsio_pkg::SHIFT_ADDR);
		chk(rd_v, tx);
		chk(8'(falls), 8'h08);
		chk(8'(lows), 8'h10 << code);
		chk({7'h0, pin_w.sck}, 8'h01);
	endtask

	task automatic t_gated();
		int s;
		wr(twsio_pkg::MODE_ADDR, 8'h02);
		wr(twsio_pkg::SHIFT_ADDR, 8'h77);
		s = n_done;
		falls = 0;
		wr(twsio_pkg::MODE_ADDR, 8'h82);
		repeat (100) @(posedge i_ref_clk);
		chk(8'(falls), 8'h00);
		chk(8'(n_done - s), 8'h00);
	endtask

	task automatic t_external();
		lsb = 1'b0;
		tx = 8'hc3;
		wr(twsio_pkg::MODE_ADDR, 8'h00);
		wr(twsio_pkg::DIR_ADDR, 8'h05);
		wr(twsio_pkg::MODE_ADDR, 8'h80);
		u_twsio_peer.start();
		wr(twsio_pkg::SHIFT_ADDR, 8'h5a);
		fork
			u_twsio_peer.ext_byte(8);
			begin
				repeat (40) @(posedge i_ref_clk);
				wr(twsio_pkg::SHIFT_ADDR, 8'hff);
			end
		join
		wait_done(20);
		chk(rx, 8'h5a);
		rd(twsio_pkg::SHIFT_ADDR);
		chk(rd_v, tx);
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		t_reset();
		t_ports();
		for (int c = 0; c < 4; c++)
			t_internal(2'(c));
		t_gated();
		t_external();
		complete_run();
	end

	// Watchdog well beyond the fewer than a thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		num_errors++;
		complete_run();
	end
endmodule
